// *** pkg/fpes_pkg.sv ***
// Register map, control fields, keys, row and page geometry and states for the flash sequencer
`default_nettype none
package fpes_pkg;
   localparam logic [3:0] ADDR_CONTROL = 4'h0;
   localparam logic [3:0] ADDR_CONTROL_CLR = 4'h1;
   localparam logic [3:0] ADDR_CONTROL_SET = 4'h2;
   localparam logic [3:0] ADDR_KEY = 4'h4;
   localparam logic [3:0] ADDR_TARGET = 4'h5;
   localparam logic [3:0] ADDR_WDATA = 4'h6;
   localparam logic [3:0] ADDR_SOURCE = 4'h7;
   localparam logic [3:0] ADDR_EVENT = 4'h8;
   localparam int GO_BIT = 15;
   localparam int PERMIT_BIT = 14;
   localparam int WFAULT_BIT = 13;
   localparam int LVFAULT_BIT = 12;
   localparam int LVSTATE_BIT = 11;
   localparam int EV_FLAG_BIT = 0;
   localparam int EV_MASK_BIT = 1;
   localparam logic [3:0] OP_WORD = 4'h1;
   localparam logic [3:0] OP_ROW = 4'h3;
   localparam logic [3:0] OP_PAGE = 4'h4;
   localparam logic [3:0] OP_ARRAY = 4'h5;
   localparam logic [31:0] KEY_FIRST = 32'haa996655;
   localparam logic [31:0] KEY_SECOND = 32'h556699aa;
   localparam logic [31:0] ROW_MASK = 32'hfffffe00;
   localparam logic [31:0] PAGE_MASK = 32'hfffff000;
   localparam logic [7:0] ROW_WORDS = 8'h80;
   localparam logic [31:0] WORD_STEP = 32'h00000004;
   localparam int PAGE_SHIFT = 12;
   localparam logic [15:0] RESET_CONTROL = 16'h0000;
   typedef enum logic [4:0] {
      FPES_IDLE = 5'h01,
      FPES_FETCH = 5'h02,
      FPES_WRITE = 5'h04,
      FPES_BUSY = 5'h08,
      FPES_DONE = 5'h10
   } fpes_state_type;
   typedef enum logic [2:0] {
      FPES_K_LOCKED = 3'h1,
      FPES_K_HALF = 3'h2,
      FPES_K_OPEN = 3'h4
   } fpes_key_type;
endpackage : fpes_pkg
`default_nettype wire

// *** hw/fpes_top.sv ***
// Flash program and erase sequencer with register port
// Function
// - Word program writes data word at address
// - Go bit clears when operation ends
// - Row program fetches 512 bytes from SRAM
// - Row start ignores sub-row address bits
// - Page erase ignores low address bits
// - Protected pages refuse erase
// - Array erase spares boot, needs no protection
// - Control codes select word, row, page
// - Code 0x4005 selects whole-array erase
// - Fault bits report outcome
// - Sleep waits for operation to finish
// - Idle keeps stall until operation ends
// - Debug suspends key sequence, no freeze
// - Device reset clears permit, lvstate, keys
// - Power-on reset clears every register
// - Watchdog reset leaves registers alone
// - Event flag sticky regardless of mask
// - Interrupt only when mask set
// - Go writable only with permit set
// - Only next transaction after keys starts
// - Fault and low-voltage flags in control
//
// Chosen here: the strobed register port and the register offsets.
`default_nettype none
module fpes_top
   import fpes_pkg::*;
#(
   parameter int unsigned BUSY_CYCLES = 16
) (
   input wire logic CORE_CLK_I,
   input wire logic RST_B_I,
   input wire logic DEV_RST_B_I,
   input wire logic [3:0] ADDR_I,
   input wire logic [31:0] WDATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   output logic [31:0] RDATA_O,
   input wire logic DEBUG_I,
   input wire logic SLEEP_REQ_I,
   output logic SLEEP_ACK_O,
   output logic CPU_STALL_O,
   input wire logic LOW_VOLTAGE_I,
   input wire logic BOOT_PROTECT_I,
   input wire logic [31:0] PROTECT_LIMIT_I,
   input wire logic BOOT_SELECT_I,
   output logic SRAM_RD_O,
   output logic [31:0] SRAM_ADDR_O,
   input wire logic [31:0] SRAM_DATA_I,
   output logic FLASH_WR_O,
   output logic [31:0] FLASH_ADDR_O,
   output logic [31:0] FLASH_DATA_O,
   output logic FLASH_PAGE_ERASE_O,
   output logic FLASH_ARRAY_ERASE_O,
   input wire logic FLASH_DONE_I,
   output logic LVD_ENABLE_O,
   output logic IRQ_O
);
   typedef struct packed {
      fpes_state_type state;
      fpes_key_type key;
      logic go;
      logic permit;
      logic wfault;
      logic lvfault;
      logic lvstate;
      logic [3:0] op;
      logic [31:0] target;
      logic [31:0] wdata;
      logic [31:0] source;
      logic ev_flag;
      logic ev_mask;
      logic [7:0] words;
      logic [31:0] rdata;
      logic sram_rd;
      logic [31:0] sram_addr;
      logic flash_wr;
      logic [31:0] flash_addr;
      logic [31:0] flash_data;
      logic page_erase;
      logic array_erase;
      logic sleep_ack;
      logic irq;
   } fpes_regs_type;

   fpes_regs_type r;
   fpes_regs_type next_r;
   logic bus_cycle;
   logic page_prot;
   logic [15:0] control_view;

   assign bus_cycle = WR_I | RD_I;
   assign control_view = {r.go, r.permit, r.wfault, r.lvfault, r.lvstate,
      7'h00, r.op};
   // Boot pages hang on one bit, main pages below a protect limit
   assign page_prot = BOOT_SELECT_I ? BOOT_PROTECT_I
      : ((r.target & PAGE_MASK) < PROTECT_LIMIT_I);

   always_comb begin
      next_r = r;
      next_r.rdata = 32'h00000000;
      next_r.flash_wr = 1'b0;
      next_r.sram_rd = 1'b0;
      next_r.page_erase = 1'b0;
      next_r.array_erase = 1'b0;
      next_r.lvstate = LOW_VOLTAGE_I & r.permit;
      if (RD_I) begin
         case (ADDR_I)
            ADDR_CONTROL: next_r.rdata = {16'h0000, control_view};
            ADDR_TARGET: next_r.rdata = r.target;
            ADDR_WDATA: next_r.rdata = r.wdata;
            ADDR_SOURCE: next_r.rdata = r.source;
            ADDR_EVENT: next_r.rdata = {30'h0, r.ev_mask, r.ev_flag};
            default: next_r.rdata = 32'h00000000;
         endcase
      end
      // Key state only steps on bus traffic; debug holds it
      if (bus_cycle && !DEBUG_I) begin
         case (r.key)
            FPES_K_LOCKED: begin
               if (WR_I && ADDR_I == ADDR_KEY && WDATA_I == KEY_FIRST) begin
                  next_r.key = FPES_K_HALF;
               end
            end
            FPES_K_HALF: begin
               if (WR_I && ADDR_I == ADDR_KEY && WDATA_I == KEY_SECOND) begin
                  next_r.key = FPES_K_OPEN;
               end else begin
                  next_r.key = FPES_K_LOCKED;
               end
            end
            FPES_K_OPEN: next_r.key = FPES_K_LOCKED;
            default: next_r.key = FPES_K_LOCKED;
         endcase
      end
      if (WR_I && r.state == FPES_IDLE) begin
         case (ADDR_I)
            ADDR_CONTROL: begin
               next_r.permit = WDATA_I[PERMIT_BIT];
               next_r.op = WDATA_I[3:0];
               next_r.wfault = WDATA_I[WFAULT_BIT];
               next_r.lvfault = WDATA_I[LVFAULT_BIT];
            end
            ADDR_CONTROL_SET: begin
               if (WDATA_I[PERMIT_BIT]) begin
                  next_r.permit = 1'b1;
               end
               next_r.op = r.op | WDATA_I[3:0];
            end
            ADDR_CONTROL_CLR: begin
               if (WDATA_I[PERMIT_BIT]) begin
                  next_r.permit = 1'b0;
               end
               if (WDATA_I[WFAULT_BIT]) begin
                  next_r.wfault = 1'b0;
               end
               if (WDATA_I[LVFAULT_BIT]) begin
                  next_r.lvfault = 1'b0;
               end
               next_r.op = r.op & ~WDATA_I[3:0];
            end
            ADDR_TARGET: next_r.target = WDATA_I;
            ADDR_WDATA: next_r.wdata = WDATA_I;
            ADDR_SOURCE: next_r.source = {WDATA_I[31:2], 2'b00};
            default: next_r.target = r.target;
         endcase
      end
      if (WR_I && ADDR_I == ADDR_EVENT) begin
         next_r.ev_mask = WDATA_I[EV_MASK_BIT];
         if (!WDATA_I[EV_FLAG_BIT]) begin
            next_r.ev_flag = 1'b0;
         end
      end
      case (r.state)
         FPES_IDLE: begin
            // Go needs permit and an open key on this very transaction
            if (WR_I && (ADDR_I == ADDR_CONTROL_SET
                  || ADDR_I == ADDR_CONTROL) && WDATA_I[GO_BIT]
                  && r.permit && r.key == FPES_K_OPEN) begin
               next_r.go = 1'b1;
               next_r.wfault = 1'b0;
               next_r.lvfault = 1'b0;
               next_r.words = 8'h00;
               if (LOW_VOLTAGE_I) begin
                  next_r.lvfault = 1'b1;
                  next_r.state = FPES_DONE;
               end else begin
                  case (r.op)
                     OP_WORD: begin
                        next_r.flash_addr = r.target;
                        next_r.flash_data = r.wdata;
                        next_r.flash_wr = 1'b1;
                        next_r.state = FPES_BUSY;
                     end
                     OP_ROW: begin
                        next_r.flash_addr = r.target & ROW_MASK;
                        next_r.sram_addr = r.source;
                        next_r.sram_rd = 1'b1;
                        next_r.state = FPES_FETCH;
                     end
                     OP_PAGE: begin
                        next_r.flash_addr = r.target & PAGE_MASK;
                        if (page_prot) begin
                           next_r.wfault = 1'b1;
                           next_r.state = FPES_DONE;
                        end else begin
                           next_r.page_erase = 1'b1;
                           next_r.state = FPES_BUSY;
                        end
                     end
                     OP_ARRAY: begin
                        // Any protected main page blocks it
                        if (PROTECT_LIMIT_I != 32'h00000000) begin
                           next_r.wfault = 1'b1;
                           next_r.state = FPES_DONE;
                        end else begin
                           next_r.array_erase = 1'b1;
                           next_r.state = FPES_BUSY;
                        end
                     end
                     default: next_r.state = FPES_DONE;
                  endcase
               end
            end
         end
         FPES_FETCH: begin
            // SRAM data is taken in the same cycle as the read pulse
            next_r.flash_data = SRAM_DATA_I;
            next_r.flash_wr = 1'b1;
            next_r.state = FPES_WRITE;
         end
         FPES_WRITE: begin
            if (LOW_VOLTAGE_I) begin
               next_r.lvfault = 1'b1;
            end
            if (FLASH_DONE_I) begin
               next_r.words = r.words + 8'h01;
               if (r.words + 8'h01 == ROW_WORDS || LOW_VOLTAGE_I) begin
                  next_r.state = FPES_DONE;
               end else begin
                  next_r.flash_addr = r.flash_addr + WORD_STEP;
                  next_r.sram_addr = r.sram_addr + WORD_STEP;
                  next_r.sram_rd = 1'b1;
                  next_r.state = FPES_FETCH;
               end
            end
         end
         FPES_BUSY: begin
            if (LOW_VOLTAGE_I) begin
               next_r.lvfault = 1'b1;
            end
            if (FLASH_DONE_I) begin
               next_r.state = FPES_DONE;
            end
         end
         FPES_DONE: begin
            next_r.go = 1'b0;
            next_r.ev_flag = 1'b1;
            next_r.state = FPES_IDLE;
         end
         default: next_r.state = FPES_IDLE;
      endcase
      // Sleep granted only with no operation running
      next_r.sleep_ack = SLEEP_REQ_I && next_r.state == FPES_IDLE
         && !next_r.go;
      next_r.irq = next_r.ev_flag & next_r.ev_mask;
   end

   // Power-on reset clears all; device reset only permit, lvstate, keys
   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_B_I) begin
         r <= '{state: FPES_IDLE, key: FPES_K_LOCKED, default: '0};
      end else if (!DEV_RST_B_I) begin
         r <= next_r;
         r.permit <= RESET_CONTROL[PERMIT_BIT];
         r.lvstate <= RESET_CONTROL[LVSTATE_BIT];
         r.key <= FPES_K_LOCKED;
      end else begin
         r <= next_r;
      end
   end

   assign RDATA_O = r.rdata;
   assign SLEEP_ACK_O = r.sleep_ack;
   assign CPU_STALL_O = r.go;
   assign SRAM_RD_O = r.sram_rd;
   assign SRAM_ADDR_O = r.sram_addr;
   assign FLASH_WR_O = r.flash_wr;
   assign FLASH_ADDR_O = r.flash_addr;
   assign FLASH_DATA_O = r.flash_data;
   assign FLASH_PAGE_ERASE_O = r.page_erase;
   assign FLASH_ARRAY_ERASE_O = r.array_erase;
   assign LVD_ENABLE_O = r.permit;
   assign IRQ_O = r.irq;

   a_go_needs_key: assert property (@(posedge CORE_CLK_I) disable iff
      (!RST_B_I) $rose(r.go) |-> $past(r.key) == FPES_K_OPEN
      && $past(r.permit)) else $error("go set without unlock");
   a_go_clears: assert property (@(posedge CORE_CLK_I) disable iff
      (!RST_B_I) r.state == FPES_DONE |=> !r.go && r.ev_flag)
      else $error("go not cleared at end");
   a_irq_masked: assert property (@(posedge CORE_CLK_I) disable iff
      (!RST_B_I) IRQ_O |-> $past(next_r.ev_mask))
      else $error("irq without mask");
   a_row_aligned: assert property (@(posedge CORE_CLK_I) disable iff
      (!RST_B_I) (r.state == FPES_FETCH && r.words == 8'h00)
      |-> r.flash_addr[8:0] == 9'h000)
      else $error("row start misaligned");
   a_prot_refuse: assert property (@(posedge CORE_CLK_I) disable iff
      (!RST_B_I) FLASH_PAGE_ERASE_O |-> !$past(page_prot))
      else $error("protected page erased");
   a_sleep_idle: assert property (@(posedge CORE_CLK_I) disable iff
      (!RST_B_I) SLEEP_ACK_O |-> !r.go)
      else $error("sleep during operation");
   a_debug_hold: assert property (@(posedge CORE_CLK_I) disable iff
      (!RST_B_I || !DEV_RST_B_I) DEBUG_I |=> r.key == $past(r.key))
      else $error("key moved in debug");
   a_flag_sticky: assert property (@(posedge CORE_CLK_I) disable iff
      (!RST_B_I) r.ev_flag && !(WR_I && ADDR_I == ADDR_EVENT) |=> r.ev_flag)
      else $error("event flag lost");
endmodule : fpes_top
`default_nettype wire

// *** dv/fpes_tb.sv ***
// Self-checking testbench for the flash program and erase sequencer
`default_nettype none
module testbench import fpes_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic CORE_CLK_I = 1'b0;
   logic RST_B_I, DEV_RST_B_I, WR_I, RD_I, DEBUG_I, SLEEP_REQ_I;
   logic LOW_VOLTAGE_I, BOOT_PROTECT_I, BOOT_SELECT_I, FLASH_DONE_I;
   logic [3:0] ADDR_I;
   logic [31:0] WDATA_I, PROTECT_LIMIT_I, SRAM_DATA_I;
   logic [31:0] RDATA_O, SRAM_ADDR_O, FLASH_ADDR_O, FLASH_DATA_O;
   logic SLEEP_ACK_O, CPU_STALL_O, SRAM_RD_O, FLASH_WR_O, LVD_ENABLE_O;
   logic FLASH_PAGE_ERASE_O, FLASH_ARRAY_ERASE_O, IRQ_O;
   logic [1:0] dly = 2'b00;
   logic [31:0] e_addr, v;
   logic [31:0] wa[$];
   logic [31:0] wd[$];
   int n_rd, n_pe, n_ae, error_cnt, n_tests;
   logic [31:0] tb_ctl[4] = '{32'h4004, 32'h4004, 32'h4005, 32'h4005};
   logic [31:0] tb_lim[4] = '{32'h1d010000, 0, 32'h1d010000, 0};

   fpes_top u_dut (.CORE_CLK_I, .RST_B_I, .DEV_RST_B_I, .ADDR_I, .WDATA_I,
      .WR_I, .RD_I, .RDATA_O, .DEBUG_I, .SLEEP_REQ_I, .SLEEP_ACK_O,
      .CPU_STALL_O, .LOW_VOLTAGE_I, .BOOT_PROTECT_I, .PROTECT_LIMIT_I,
      .BOOT_SELECT_I, .SRAM_RD_O, .SRAM_ADDR_O, .SRAM_DATA_I, .FLASH_WR_O,
      .FLASH_ADDR_O, .FLASH_DATA_O, .FLASH_PAGE_ERASE_O,
      .FLASH_ARRAY_ERASE_O, .FLASH_DONE_I, .LVD_ENABLE_O, .IRQ_O);

   always #4 CORE_CLK_I = ~CORE_CLK_I;

   // Observe at the falling edge so registered outputs are settled
   always @(negedge CORE_CLK_I) begin
      dly = {dly[0], FLASH_WR_O | FLASH_PAGE_ERASE_O | FLASH_ARRAY_ERASE_O};
      if (SRAM_RD_O === 1'b1) n_rd++;
      if (FLASH_WR_O === 1'b1) begin
         wa.push_back(FLASH_ADDR_O);
         wd.push_back(FLASH_DATA_O);
      end
      if (FLASH_PAGE_ERASE_O === 1'b1) begin
         n_pe++;
         e_addr = FLASH_ADDR_O;
      end
      if (FLASH_ARRAY_ERASE_O === 1'b1) n_ae++;
   end

   // Flash macro answers on the rising edge
   always @(posedge CORE_CLK_I) begin
      FLASH_DONE_I <= dly[1];
   end

   // SRAM reads through: design captures at the end of its read pulse
   assign SRAM_DATA_I = ~SRAM_ADDR_O;

   task automatic chk(input string nm, input logic [31:0] e, g);
      n_tests++;
      if (g !== e) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // A gap cycle between strobes keeps each strobe a clean pulse
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge CORE_CLK_I);
      ADDR_I <= a;
      WDATA_I <= d;
      WR_I <= 1'b1;
      @(posedge CORE_CLK_I);
      WR_I <= 1'b0;
   endtask : wr

   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge CORE_CLK_I);
      ADDR_I <= a;
      RD_I <= 1'b1;
      @(posedge CORE_CLK_I);
      RD_I <= 1'b0;
      #1 d = RDATA_O;
   endtask : rd

   task automatic unlock(input logic [31:0] ctl);
      wr(ADDR_CONTROL, ctl);
      wr(ADDR_KEY, KEY_FIRST);
      wr(ADDR_KEY, KEY_SECOND);
   endtask : unlock

   task automatic run(input logic [31:0] ctl, input logic busy);
      int i;
      unlock(ctl);
      wr(ADDR_CONTROL_SET, 32'h00008000);
      if (busy) begin
         repeat (2) @(posedge CORE_CLK_I);
         #1 chk("cpu stall", 32'h1, {31'h0, CPU_STALL_O});
         chk("sleep ack busy", 32'h0, {31'h0, SLEEP_ACK_O});
      end
      v = 32'hffffffff;
      for (i = 0; i < 1500 && v[GO_BIT] !== 1'b0; i++) rd(ADDR_CONTROL, v);
      chk("go clear", 32'h0, {31'h0, v[GO_BIT]});
   endtask : run

   task automatic results();
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : results

   initial begin
      {RST_B_I, DEV_RST_B_I, WR_I, RD_I, DEBUG_I, SLEEP_REQ_I} = '0;
      {LOW_VOLTAGE_I, BOOT_PROTECT_I, BOOT_SELECT_I} = '0;
      {ADDR_I, WDATA_I, PROTECT_LIMIT_I} = '0;
      repeat (4) @(posedge CORE_CLK_I);
      RST_B_I <= 1'b1;
      DEV_RST_B_I <= 1'b1;
      rd(ADDR_CONTROL, v);
      chk("control reset", 32'h0, v);
      rd(ADDR_EVENT, v);
      chk("event reset", 32'h0, v);
      $display("test reset done");
      wr(ADDR_WDATA, 32'hdeadbeef);
      wr(ADDR_TARGET, 32'h1d000104);
      SLEEP_REQ_I <= 1'b1;
      run(32'h4001, 1'b1);
      chk("word writes", 32'h1, wa.size());
      chk("word addr", 32'h1d000104, wa[0]);
      chk("word data", 32'hdeadbeef, wd[0]);
      chk("lvd enable", 32'h1, {31'h0, LVD_ENABLE_O});
      repeat (2) @(posedge CORE_CLK_I);
      #1 chk("sleep ack idle", 32'h1, {31'h0, SLEEP_ACK_O});
      @(posedge CORE_CLK_I);
      SLEEP_REQ_I <= 1'b0;
      rd(ADDR_EVENT, v);
      chk("event flag", 32'h1, v);
      chk("irq masked", 32'h0, {31'h0, IRQ_O});
      wr(ADDR_EVENT, 32'h3);
      @(posedge CORE_CLK_I);
      #1 chk("irq open", 32'h1, {31'h0, IRQ_O});
      wr(ADDR_EVENT, 32'h2);
      @(posedge CORE_CLK_I);
      #1 chk("irq cleared", 32'h0, {31'h0, IRQ_O});
      $display("test word done");
      wr(ADDR_TARGET, 32'h1d000a7c);
      wr(ADDR_SOURCE, 32'h00001200);
      wa.delete();
      wd.delete();
      n_rd = 0;
      run(32'h4003, 1'b1);
      chk("sram reads", 32'd128, n_rd);
      chk("row writes", 32'd128, wa.size());
      chk("row first addr", 32'h1d000a00, wa[0]);
      chk("row last addr", 32'h1d000bfc, wa[127]);
      chk("row first data", ~32'h00001200, wd[0]);
      chk("row last data", ~32'h000013fc, wd[127]);
      $display("test row done");
      wr(ADDR_TARGET, 32'h1d000abc);
      for (int k = 0; k < 4; k++) begin
         PROTECT_LIMIT_I <= tb_lim[k];
         n_pe = 0;
         n_ae = 0;
         run(tb_ctl[k], tb_lim[k] == 0);
         chk("page pulses", k == 1, n_pe);
         chk("array pulses", k == 3, n_ae);
         if (k == 1) chk("page addr", 32'h1d000000, e_addr);
         if (tb_lim[k] != 0) chk("fault", 32'h1, v[WFAULT_BIT]);
      end
      $display("test erase done");
      wa.delete();
      unlock(32'h4001);
      rd(ADDR_EVENT, v);
      wr(ADDR_CONTROL_SET, 32'h00008000);
      rd(ADDR_CONTROL, v);
      chk("relocked go", 32'h0, v[GO_BIT]);
      unlock(32'h0001);
      wr(ADDR_CONTROL_SET, 32'h00008000);
      rd(ADDR_CONTROL, v);
      chk("no permit go", 32'h0, v[GO_BIT]);
      repeat (6) @(posedge CORE_CLK_I);
      chk("no writes", 32'h0, wa.size());
      $display("test lock done");
      wr(ADDR_TARGET, 32'h1d000200);
      wr(ADDR_CONTROL, 32'h4001);
      @(posedge CORE_CLK_I);
      DEV_RST_B_I <= 1'b0;
      repeat (2) @(posedge CORE_CLK_I);
      DEV_RST_B_I <= 1'b1;
      rd(ADDR_CONTROL, v);
      chk("dev reset ctl", 32'h1, v & 32'h0000c80f);
      chk("dev reset lvd", 32'h0, {31'h0, LVD_ENABLE_O});
      rd(ADDR_TARGET, v);
      chk("dev reset target", 32'h1d000200, v);
      $display("test device reset done");
      wa.delete();
      unlock(32'h4001);
      DEBUG_I <= 1'b1;
      rd(ADDR_EVENT, v);
      @(posedge CORE_CLK_I);
      DEBUG_I <= 1'b0;
      wr(ADDR_CONTROL_SET, 32'h00008000);
      v = 32'hffffffff;
      for (int i = 0; i < 1500 && v[GO_BIT] !== 1'b0; i++) rd(ADDR_CONTROL, v);
      chk("debug go clear", 32'h0, v[GO_BIT]);
      chk("debug writes", 32'h1, wa.size());
      wr(ADDR_CONTROL_CLR, 32'h00004000);
      @(posedge CORE_CLK_I);
      #1 chk("permit cleared", 32'h0, {31'h0, LVD_ENABLE_O});
      $display("test debug done");
      results();
   end

   // Whole run needs under a thousand cycles
   initial begin
      repeat (20000) @(posedge CORE_CLK_I);
      error_cnt++;
      results();
   end
endmodule : testbench
`default_nettype wire
